// ==== hw/asc_sequencer.sv ====
// converter sequencer: registers, sample/convert control, mux steering, result buffer
`timescale 1ns/1ns
module asc_sequencer
  import asc_pkg::*;
#(
  parameter int NUM_INPUTS = 10,
  parameter int BUF_WORDS = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic timerTrig,
  input wire logic extTrig,
  input wire logic sleepReq,
  input wire logic rcTick,
  input wire logic compHigh,
  output asc_analog_t analogCtl,
  output logic [11:0] sarTrial,
  output logic convIrq
);

  // software-written configuration
  logic [15:0] ctrl1_q, seq_q, clk_q, chsel_q, scan_q;
  logic sample_control_bit_q, done_q;
  asc_state_t state_q;
  logic [5:0] tadDiv_q;
  logic tadTick;
  logic [4:0] samcCnt_q;
  logic [3:0] convCnt_q;
  logic [11:0] sar_q;
  logic [3:0] smpCnt_q;
  logic [3:0] wrPtr_q;
  logic half_q, altB_q;
  logic [3:0] scanPos_q;
  logic [11:0] mem_q [BUF_WORDS];
  logic trigS1_q, trigS2_q, trigPrev_q, extS1_q, extS2_q, extPrev_q, cmpS1_q, cmpS2_q;
  logic rcS1_q, rcS2_q, rcPrev_q, slpS1_q, slpS2_q;

  wire logic enOn = ctrl1_q[ASC_C1_ON];
  wire logic [2:0] trigger_source_field = ctrl1_q[ASC_C1_TRIGGER_SOURCE_FIELD_LO +: 3];
  wire logic [1:0] fmt = ctrl1_q[ASC_C1_FORM_LO +: 2];
  wire logic [3:0] samples_per_interrupt = seq_q[ASC_SQ_SAMPLES_PER_INTERRUPT_LO +: 4];
  wire logic [4:0] auto_sample_clock_count = clk_q[ASC_CK_AUTO_SAMPLE_CLOCK_COUNT_LO +: 5];
  wire logic useRc = clk_q[ASC_CK_RC];

  // pin inputs pass two flops before use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trigS1_q <= 1'b0;
      trigS2_q <= 1'b0;
      extS1_q <= 1'b0;
      extS2_q <= 1'b0;
      cmpS1_q <= 1'b0;
      cmpS2_q <= 1'b0;
      rcS1_q <= 1'b0;
      rcS2_q <= 1'b0;
      slpS1_q <= 1'b0;
      slpS2_q <= 1'b0;
      trigPrev_q <= 1'b0;
      extPrev_q <= 1'b0;
      rcPrev_q <= 1'b0;
    end else begin
      trigS1_q <= timerTrig;
      trigS2_q <= trigS1_q;
      extS1_q <= extTrig;
      extS2_q <= extS1_q;
      cmpS1_q <= compHigh;
      cmpS2_q <= cmpS1_q;
      rcS1_q <= rcTick;
      rcS2_q <= rcS1_q;
      slpS1_q <= sleepReq;
      slpS2_q <= slpS1_q;
      trigPrev_q <= trigS2_q;
      extPrev_q <= extS2_q;
      rcPrev_q <= rcS2_q;
    end
  end

  // converter clock: divided system clock, or rc oscillator edges
  // system clock divider
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tadDiv_q <= 6'h00;
    end else if (tadDiv_q >= clk_q[5:0]) begin
      tadDiv_q <= 6'h00;
    end else begin
      tadDiv_q <= tadDiv_q + 6'h01;
    end
  end
  // sleep stops the system-derived clock; only the rc source runs on
  assign tadTick = useRc ? (rcS2_q & ~rcPrev_q) : (~slpS2_q & (tadDiv_q >= clk_q[5:0]));

  // trigger selection
  logic trigHit;
  always_comb begin
    trigHit = 1'b0;
    unique case (trigger_source_field)
      ASC_TRIG_SW: trigHit = ~sample_control_bit_q;
      ASC_TRIG_TMR: trigHit = trigS2_q & ~trigPrev_q;
      ASC_TRIG_EXT: trigHit = extS2_q & ~extPrev_q;
      ASC_TRIG_AUTO: trigHit = tadTick && (samcCnt_q + 5'h01 >= ((auto_sample_clock_count == 5'h00) ? 5'h01 : auto_sample_clock_count));
      default: trigHit = 1'b0;
    endcase
  end

  wire logic writeSamp = regWr && regAddr == {1'b0, ASC_ADDR_CTRL1};
  wire logic convEnd = (state_q == ASC_CONVERT) && tadTick && (convCnt_q == ASC_CONV_TAD - 4'h1);
  wire logic irqEvent = convEnd && (smpCnt_q == samples_per_interrupt);

  // configuration registers; sample bit also auto-cleared by triggers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1_q <= ASC_RST_REG;
      seq_q <= ASC_RST_REG;
      clk_q <= ASC_RST_REG;
      chsel_q <= ASC_RST_REG;
      scan_q <= ASC_RST_REG;
    end else if (regWr) begin
      unique case (regAddr)
        {1'b0, ASC_ADDR_CTRL1}: ctrl1_q <= regWdata;
        // no write guard; software keeps off while enabled
        {1'b0, ASC_ADDR_SEQ}: seq_q <= regWdata;
        {1'b0, ASC_ADDR_CLK}: clk_q <= regWdata;
        {1'b0, ASC_ADDR_CHSEL}: chsel_q <= regWdata;
        {1'b0, ASC_ADDR_SCAN}: scan_q <= regWdata;
        default: ;
      endcase
    end
  end

  // sample bit: software sets, hardware clears on trigger in non-software modes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_control_bit_q <= 1'b0;
    end else if (writeSamp) begin
      sample_control_bit_q <= regWdata[ASC_C1_SAMPLE_CONTROL_BIT];
    end else if (!enOn) begin
      sample_control_bit_q <= 1'b0;
    end else if (state_q == ASC_SAMPLE && trigHit && trigger_source_field != ASC_TRIG_SW) begin
      sample_control_bit_q <= 1'b0;
    end else if (ctrl1_q[ASC_C1_AUTO_SAMPLE_BIT] && convEnd) begin
      sample_control_bit_q <= 1'b1;
    end
  end

  // sequencer state machine
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ASC_IDLE;
      samcCnt_q <= 5'h00;
      convCnt_q <= 4'h0;
    end else if (!enOn && (state_q == ASC_SAMPLE || state_q == ASC_CONVERT)) begin
      state_q <= ASC_HOLDOFF;
      convCnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        ASC_IDLE: begin
          if (enOn && sample_control_bit_q) begin
            state_q <= ASC_SAMPLE;
            samcCnt_q <= 5'h00;
          end
        end
        ASC_SAMPLE: begin
          if (trigHit) begin
            state_q <= ASC_CONVERT;
            convCnt_q <= 4'h0;
          end else if (tadTick) begin
            samcCnt_q <= samcCnt_q + 5'h01;
          end
        end
        ASC_CONVERT: begin
          if (convEnd) begin
            state_q <= ASC_IDLE;
          end else if (tadTick) begin
            convCnt_q <= convCnt_q + 4'h1;
          end
        end
        ASC_HOLDOFF: begin
          // short wait after an abort before sampling again
          if (tadTick) begin
            convCnt_q <= convCnt_q + 4'h1;
          end
          if (convCnt_q >= {2'b00, ASC_ABORT_TAD}) begin
            state_q <= ASC_IDLE;
          end
        end
        default: state_q <= ASC_IDLE;
      endcase
    end
  end

  // successive approximation, msb first, one bit per converter clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sar_q <= 12'h000;
    end else if (state_q == ASC_SAMPLE) begin
      sar_q <= 12'h800;
    end else if (state_q == ASC_CONVERT && tadTick && convCnt_q < 4'hc) begin
      // clear the trial bit if the input is below it, set the next one
      sar_q <= (cmpS2_q ? sar_q : (sar_q & ~(12'h800 >> convCnt_q)))
               | ((convCnt_q < 4'hb) ? (12'h400 >> convCnt_q) : 12'h000);
    end
  end

  // sample counter, buffer half, write pointer, alternate group
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smpCnt_q <= 4'h0;
      wrPtr_q <= 4'h0;
      half_q <= 1'b0;
      altB_q <= 1'b0;
    end else if (!enOn) begin
      smpCnt_q <= 4'h0;
      wrPtr_q <= 4'h0;
      half_q <= 1'b0;
      altB_q <= 1'b0;
    end else if (convEnd) begin
      altB_q <= seq_q[ASC_SQ_ALTERNATE_INPUT_BIT] & ~altB_q;
      if (irqEvent) begin
        smpCnt_q <= 4'h0;
        half_q <= seq_q[ASC_SQ_BUFFER_SPLIT_BIT] & ~half_q;
        wrPtr_q <= 4'h0;
      end else begin
        smpCnt_q <= smpCnt_q + 4'h1;
        wrPtr_q <= wrPtr_q + 4'h1;
      end
    end
  end

  // count field holds N-1, compared directly
  // result store; bus writes never touch it
  wire logic [3:0] wrAddr = seq_q[ASC_SQ_BUFFER_SPLIT_BIT] ? {half_q, wrPtr_q[2:0]} : wrPtr_q;
  always_ff @(posedge clk) begin
    if (convEnd) begin
      mem_q[wrAddr] <= sar_q;
    end
  end

  // done bit and interrupt flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
      convIrq <= 1'b0;
    end else begin
      // after N samples; cleared at new sampling
      if (irqEvent) begin
        done_q <= 1'b1;
      end else if (state_q == ASC_IDLE && enOn && sample_control_bit_q) begin
        done_q <= 1'b0;
      end
      convIrq <= irqEvent;
    end
  end

  // scan pointer; ascending, restart at interrupt
  // set bits select; high ones left out
  function automatic logic [3:0] nextScan(input logic [15:0] sel, input logic [4:0] from);
    logic [3:0] hit;
    logic found;
    hit = 4'h0;
    found = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (!found && sel[i] && i >= int'(from)) begin
        hit = 4'(i);
        found = 1'b1;
      end
    end
    return hit;
  endfunction

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scanPos_q <= 4'h0;
    end else if (!enOn || irqEvent) begin
      scanPos_q <= nextScan(scan_q, 5'h00);
    end else if (convEnd && !altB_q) begin
      scanPos_q <= nextScan(scan_q, {1'b0, scanPos_q} + 5'h01);
    end
  end

  // input steering; second group when alternating, else scan pointer in scan mode, else first group
  logic [3:0] chanSel;
  always_comb begin
    if (altB_q) begin
      chanSel = chsel_q[11:8];
    end else if (seq_q[ASC_SQ_SCAN]) begin
      chanSel = scanPos_q;
    end else begin
      chanSel = chsel_q[3:0];
    end
  end

  // analog side outputs, registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      analogCtl <= '0;
      sarTrial <= 12'h000;
    end else begin
      analogCtl.sampleHold <= (state_q == ASC_SAMPLE);
      analogCtl.convStart <= (state_q == ASC_SAMPLE) && trigHit;
      analogCtl.posChan <= chanSel;
      analogCtl.negChan <= altB_q ? chsel_q[12] : chsel_q[4];
      analogCtl.refSel <= seq_q[ASC_SQ_VREF_LO +: 2];
      sarTrial <= sar_q;
    end
  end

  // formatted read of a stored word
  function automatic logic [15:0] fmtWord(input logic [11:0] w, input logic [1:0] f);
    logic [15:0] r;
    r = {4'h0, w};
    unique case (f)
      ASC_FMT_UINT: r = {4'h0, w};
      ASC_FMT_SINT: r = {{5{~w[11]}}, w[10:0]};
      ASC_FMT_UFRAC: r = {w, 4'h0};
      ASC_FMT_SFRAC: r = {~w[11], w[10:0], 4'h0};
    endcase
    return r;
  endfunction

  // read port: data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      if (regAddr[4]) begin
        regRdata <= fmtWord(mem_q[regAddr[3:0]], fmt);
      end else begin
        unique case (regAddr)
          {1'b0, ASC_ADDR_CTRL1}: regRdata <= {ctrl1_q[15:2], sample_control_bit_q, done_q};
          {1'b0, ASC_ADDR_SEQ}: regRdata <= seq_q;
          {1'b0, ASC_ADDR_CLK}: regRdata <= clk_q;
          {1'b0, ASC_ADDR_CHSEL}: regRdata <= chsel_q;
          {1'b0, ASC_ADDR_SCAN}: regRdata <= scan_q;
          {1'b0, ASC_ADDR_STAT}: regRdata <= {8'h00, half_q, altB_q, 2'b00, state_q};
          default: regRdata <= 16'h0000;
        endcase
      end
    end else begin
      regRdata <= 16'h0000;
    end
  end

endmodule // asc_sequencer

// ==== inc/asc_pkg.sv ====
// package: register map, field layout and timing constants of the converter sequencer
package asc_pkg;
  // register word addresses (plain port, word index)
  localparam logic [3:0] ASC_ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ASC_ADDR_SEQ = 4'h1;
  localparam logic [3:0] ASC_ADDR_CLK = 4'h2;
  localparam logic [3:0] ASC_ADDR_CHSEL = 4'h3;
  localparam logic [3:0] ASC_ADDR_SCAN = 4'h4;
  localparam logic [3:0] ASC_ADDR_STAT = 4'h5;
  // result buffer occupies addresses 0x10..0x1f
  localparam logic [4:0] ASC_ADDR_BUF_BASE = 5'h10;
  // control register 1 fields
  localparam int ASC_C1_ON = 15;
  localparam int ASC_C1_FORM_LO = 8;
  localparam int ASC_C1_TRIGGER_SOURCE_FIELD_LO = 5;
  localparam int ASC_C1_AUTO_SAMPLE_BIT = 2;
  localparam int ASC_C1_SAMPLE_CONTROL_BIT = 1;
  localparam int ASC_C1_DONE = 0;
  // sequence control register fields
  localparam int ASC_SQ_VREF_LO = 13;
  localparam int ASC_SQ_SCAN = 10;
  localparam int ASC_SQ_SAMPLES_PER_INTERRUPT_LO = 2;
  localparam int ASC_SQ_BUFFER_SPLIT_BIT = 1;
  localparam int ASC_SQ_ALTERNATE_INPUT_BIT = 0;
  // clock register fields
  localparam int ASC_CK_AUTO_SAMPLE_CLOCK_COUNT_LO = 8;
  localparam int ASC_CK_RC = 7;
  // trigger source codes
  localparam logic [2:0] ASC_TRIG_SW = 3'h0;
  localparam logic [2:0] ASC_TRIG_TMR = 3'h2;
  localparam logic [2:0] ASC_TRIG_EXT = 3'h1;
  localparam logic [2:0] ASC_TRIG_AUTO = 3'h7;
  // output formats
  localparam logic [1:0] ASC_FMT_UINT = 2'h0;
  localparam logic [1:0] ASC_FMT_SINT = 2'h1;
  localparam logic [1:0] ASC_FMT_UFRAC = 2'h2;
  localparam logic [1:0] ASC_FMT_SFRAC = 2'h3;
  // conversion takes this many converter clock periods
  localparam logic [3:0] ASC_CONV_TAD = 4'he;
  // wait after an abort before sampling again, in converter clocks
  localparam logic [1:0] ASC_ABORT_TAD = 2'h2;
  // reset values
  localparam logic [15:0] ASC_RST_REG = 16'h0000;
  // analog side controls travel together
  typedef struct packed {
    logic sampleHold;
    logic convStart;
    logic [3:0] posChan;
    logic negChan;
    logic [1:0] refSel;
  } asc_analog_t;
  // trial word to the comparator and its answer
  typedef struct packed {
    logic [11:0] trial;
    logic compHigh;
  } asc_sar_t;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ASC_IDLE = 4'b0001,
    ASC_SAMPLE = 4'b0010,
    ASC_CONVERT = 4'b0100,
    ASC_HOLDOFF = 4'b1000
  } asc_state_t;
endpackage

// ==== verif/asc_sar_model.sv ====
// behavioural analog front end: input mux, sample-hold and comparator
`timescale 1ns/1ns
module asc_sar_model
  import asc_pkg::*;
(
  input wire logic clk,
  input wire asc_analog_t analogCtl,
  input wire logic [11:0] sarTrial,
  output logic compHigh
);
  logic [11:0] heldQ = 12'h000;
  // one shared hold
  // level follows the selected input only while sampling, then is frozen
  always_ff @(posedge clk) begin
    if (analogCtl.sampleHold) heldQ <= {analogCtl.posChan, 8'h5a};
  end
  // comparator against trial
  // combinational answer: the worst case for the sequencer's input sync
  assign compHigh = (heldQ >= sarTrial);
endmodule // asc_sar_model

// ==== verif/asc_sequencer_asserts.sv ====
// port assertions for the converter sequencer
`timescale 1ns/1ns
module asc_sequencer_asserts
  import asc_pkg::*;
#(
  parameter int NUM_INPUTS = 10,
  parameter int BUF_WORDS = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  input wire logic timerTrig,
  input wire logic extTrig,
  input wire logic sleepReq,
  input wire logic rcTick,
  input wire logic compHigh,
  input wire asc_analog_t analogCtl,
  input wire logic [11:0] sarTrial,
  input wire logic convIrq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // first control register decode
  logic c1Wr;
  logic c1Rd;
  assign c1Wr = regWr && regAddr == {1'b0, ASC_ADDR_CTRL1};
  assign c1Rd = regRd && regAddr == {1'b0, ASC_ADDR_CTRL1};
  // a conversion gives no result in its first cycles
  sequence noIrq8;
    (!convIrq) [*8];
  endsequence
  // nothing moves once the converter is off
  sequence idle8;
    (!analogCtl.sampleHold && !analogCtl.convStart && !convIrq) [*8];
  endsequence
  AST_MUX_RANGE: assert property (
    analogCtl.sampleHold |-> analogCtl.posChan < NUM_INPUTS) else $error("input out of range");
  AST_SAMPLE_START: assert property (
    c1Wr && regWdata[ASC_C1_ON] && regWdata[ASC_C1_SAMPLE_CONTROL_BIT] |-> ##[1:5] analogCtl.sampleHold)
    else $error("sampling did not start");
  AST_SW_TRIGGER: assert property (
    c1Wr && regWdata[ASC_C1_ON] && regWdata[ASC_C1_TRIGGER_SOURCE_FIELD_LO +: 3] == ASC_TRIG_SW
    && !regWdata[ASC_C1_SAMPLE_CONTROL_BIT] && analogCtl.sampleHold |-> ##[1:12] analogCtl.convStart)
    else $error("no conversion after sample bit cleared");
  AST_CONV_QUIET: assert property (
    $rose(analogCtl.convStart) |-> ##2 (!analogCtl.sampleHold) [*8])
    else $error("sampling during conversion");
  AST_CONV_NO_IRQ: assert property ($rose(analogCtl.convStart) |-> noIrq8)
    else $error("interrupt too soon after conversion start");
  AST_IRQ_PULSE: assert property (convIrq |=> !convIrq)
    else $error("interrupt longer than one cycle");
  AST_DISABLE_STOP: assert property (c1Wr && !regWdata[ASC_C1_ON] |-> ##4 idle8)
    else $error("activity after disable");
  AST_DONE_CLEAR: assert property (
    c1Wr && regWdata[ASC_C1_SAMPLE_CONTROL_BIT] ##[1:6] c1Rd |=> !regRdata[ASC_C1_DONE])
    else $error("done still set after new sampling");
endmodule // asc_sequencer_asserts

bind asc_sequencer asc_sequencer_asserts #(.NUM_INPUTS(NUM_INPUTS), .BUF_WORDS(BUF_WORDS)) u_chk (
  .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .timerTrig(timerTrig), .extTrig(extTrig),
  .sleepReq(sleepReq), .rcTick(rcTick), .compHigh(compHigh), .analogCtl(analogCtl),
  .sarTrial(sarTrial), .convIrq(convIrq)
);

// ==== verif/tb_top.sv ====
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
module tb_top
  import asc_pkg::*;
;
  localparam logic [4:0] C1 = {1'b0, ASC_ADDR_CTRL1};
  localparam logic [4:0] SQ = {1'b0, ASC_ADDR_SEQ};
  localparam logic [4:0] CK = {1'b0, ASC_ADDR_CLK};
  localparam logic [4:0] SC = {1'b0, ASC_ADDR_SCAN};
  localparam logic [15:0] AUTO = {8'h80, ASC_TRIG_AUTO, 5'h06};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic regWr = 1'b0, regRd = 1'b0, extTrig = 1'b0, timerTrig = 1'b0;
  logic sleepReq = 1'b0, rcTick = 1'b0;
  int rcCnt = 0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000, regRdata;
  logic compHigh, convIrq;
  logic [11:0] sarTrial;
  asc_analog_t analogCtl;
  int errors = 0, n_compared = 0, irqCount = 0, convCount = 0, base;
  logic [3:0] scanCh [3] = '{4'h1, 4'h4, 4'h7};

  asc_sequencer DUT (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .timerTrig(timerTrig), .extTrig(extTrig),
    .sleepReq(sleepReq), .rcTick(rcTick), .compHigh(compHigh), .analogCtl(analogCtl),
    .sarTrial(sarTrial), .convIrq(convIrq)
  );
  asc_sar_model u_sar (.clk(clk), .analogCtl(analogCtl), .sarTrial(sarTrial), .compHigh(compHigh));

  // 125 MHz system clock
  initial begin
    forever #4 clk = ~clk;
  end
  // running totals of interrupt pulses and conversion starts
  always @(posedge clk) begin
    if (convIrq === 1'b1) irqCount++;
    if (analogCtl.convStart === 1'b1) convCount++;
  end
  // free-running rc source: a rising edge every six clocks, slow enough for the comparator path
  always @(posedge clk) begin
    rcCnt <= (rcCnt == 2) ? 0 : rcCnt + 1;
    if (rcCnt == 2) rcTick <= ~rcTick;
  end

  // verdict, reached from the tests or the watchdog
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // compare one value and keep the tally
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // write cycle plus an idle cycle, so strobes never toggle twice in one step
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  // read cycle; data taken at the edge closing the answer cycle
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp, input string what);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    chk(what, regRdata, exp);
  endtask
  // bounded wait for the interrupt total
  task automatic waitIrq(input int n);
    int k;
    k = 0;
    while (irqCount < n && k < 2000) begin
      @(posedge clk);
      k++;
    end
    chk("interrupts", 16'(irqCount), 16'(n));
  endtask

  // watchdog: the tests need well under this many cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // reset value, readback, unmapped space
    rdc(C1, ASC_RST_REG, "ctrl1 reset");
    wr(SC, 16'h0292);
    rdc(SC, 16'h0292, "scan select");
    rdc(5'h0a, 16'h0000, "unmapped");
    $display("test registers done");
    // configure, enable, then sample
    // a four-clock tad leaves the comparator path time to settle
    wr(CK, 16'h0003);
    wr({1'b0, ASC_ADDR_CHSEL}, 16'h0503);
    wr(C1, 16'h8002);
    repeat (6) @(posedge clk);
    wr(C1, 16'h8000);
    waitIrq(1);
    rdc(C1, 16'h8001, "done");
    rdc(5'h10, 16'h035a, "result");
    wr(5'h10, 16'hffff);
    rdc(5'h10, 16'h035a, "buffer after write");
    wr(C1, 16'h8002);
    repeat (2) @(posedge clk);
    rdc(C1, 16'h8002, "done cleared");
    repeat (4) @(posedge clk);
    wr(C1, 16'h8000);
    repeat (10) @(posedge clk);
    // disable in mid-conversion
    wr(C1, 16'h0000);
    repeat (100) @(posedge clk);
    chk("irq after abort", 16'(irqCount), 16'd1);
    rdc(5'h10, 16'h035a, "buffer after abort");
    $display("test software trigger done");
    // auto trigger, alternating groups, four samples per interrupt
    wr(SQ, 16'h000d);
    wr(CK, 16'h0103);
    base = convCount;
    wr(C1, AUTO);
    waitIrq(2);
    chk("conversions", 16'(convCount - base), 16'd4);
    // off at once, before the next result lands in word 0
    wr(C1, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rdc(5'h10 + 5'(i), i[0] ? 16'h055a : 16'h035a, "alternate");
    end
    $display("test alternate done");
    // scan selecting inputs 1, 4, 7, 9; three samples per half buffer reach only 1, 4, 7
    // split buffer, slow drain
    wr(SQ, 16'h040a);
    base = convCount;
    wr(C1, AUTO);
    waitIrq(4);
    chk("conversions", 16'(convCount - base), 16'd6);
    wr(C1, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      rdc(5'h10 + 5'(i), {4'h0, scanCh[i], 8'h5a}, "scan low");
      rdc(5'h18 + 5'(i), {4'h0, scanCh[i], 8'h5a}, "scan high");
    end
    rdc(5'h13, 16'h055a, "unused input");
    $display("test scan done");
    // external then timer trigger ends acquisition
    wr(SQ, 16'h0000);
    for (int t = 0; t < 2; t++) begin
      wr(C1, {8'h80, t[0] ? ASC_TRIG_TMR : ASC_TRIG_EXT, 5'h02});
      repeat (8) @(posedge clk);
      extTrig <= !t[0];
      timerTrig <= t[0];
      repeat (4) @(posedge clk);
      extTrig <= 1'b0;
      timerTrig <= 1'b0;
      waitIrq(5 + t);
      wr(C1, 16'h0000);
      // stay off long enough for the quiet window after a disable
      repeat (12) @(posedge clk);
    end
    rdc(5'h10, 16'h035a, "triggered");
    $display("test triggers done");
    // asleep on the rc clock, with the other reference pair
    sleepReq <= 1'b1;
    wr(SQ, 16'h6000);
    @(posedge clk);
    chk("reference", 16'(analogCtl.refSel), 16'h0003);
    wr(CK, 16'h0080);
    wr(C1, 16'h8002);
    repeat (8) @(posedge clk);
    wr(C1, 16'h8000);
    waitIrq(7);
    rdc(C1, 16'h8001, "rc done");
    sleepReq <= 1'b0;
    wr(C1, 16'h0000);
    $display("test rc clock done");
    tally_and_finish();
  end
endmodule // tb_top
